// ### drive_stop_pkg.sv
// Purpose: Constants and types for status and stop logic
// Assumes: Indices as on the bus
// Notes:   Constants live here
// Functional notes
// RULE_01: Status bits 0..6 report the drive state machine; the code drives bit 4 from i_VOLTAGE_ON instead.
// RULE_02: Warning bit 7 follows the information condition and clears itself.
// RULE_03: Remote bit 9 stays 0 until initialization finishes, then 1.
// RULE_04: Target reached bit 10 is chosen by the active operation mode.
// RULE_05: Bit 11 flags an internal limit restricting the drive.
// RULE_06: Quick stop action accepts 0,1,2,3,5,6,7 and resets to 2.
// RULE_07: Quick stop action written mid stop applies after standstill.
// RULE_08: Quick stop 0 cuts current; 1..3 stop then go switch on disabled.
// RULE_09: Quick stop 5..7 stop and then stay in quick stop active.
// RULE_10: Quick stop during another deceleration switches to quick stop rate.
// RULE_11: Decelerations from stop input or controller bit keep their rate.
// RULE_12: Shutdown action accepts 0 or 1 and resets to 1.
// RULE_13: Disable-operation action accepts 0 or 1 and resets to 1.
// RULE_14: Action 1 decelerates at profile rate, then de-excites the motor.
// RULE_15: Halt action accepts 1, 2 or 3 and resets to 1.
// RULE_16: Halt 1..3 stops at profile, quick or immediate; stays enabled.
// RULE_17: Out-of-set action writes are refused and the old value kept.
package drive_stop_pkg;

  // ----------------------------------------------------------------
  // Object indices
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_STATUS      = 16'h6041;
  localparam logic [15:0] IDX_QS_ACTION   = 16'h605A;
  localparam logic [15:0] IDX_SHUT_ACTION = 16'h605B;
  localparam logic [15:0] IDX_DIS_ACTION  = 16'h605C;
  localparam logic [15:0] IDX_HALT_ACTION = 16'h605D;

  // ----------------------------------------------------------------
  // Reset values and legal maps (bit n set: code n legal)
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_QS_ACTION   = 16'h0002;
  localparam logic [15:0] RST_SHUT_ACTION = 16'h0001;
  localparam logic [15:0] RST_DIS_ACTION  = 16'h0001;
  localparam logic [15:0] RST_HALT_ACTION = 16'h0001;
  localparam logic [7:0]  LEGAL_QS        = 8'hEF;
  localparam logic [7:0]  LEGAL_ONOFF     = 8'h03;
  localparam logic [7:0]  LEGAL_HALT      = 8'h0E;

  // ----------------------------------------------------------------
  // Status word bit positions and operation modes
  // ----------------------------------------------------------------
  localparam int BIT_WARNING = 7;
  localparam int BIT_REMOTE  = 9;
  localparam int BIT_TARGET  = 10;
  localparam int BIT_ILIMIT  = 11;
  localparam logic [7:0] MODE_PP  = 8'h01;
  localparam logic [7:0] MODE_PV  = 8'h03;
  localparam logic [7:0] MODE_HM  = 8'h06;
  localparam logic [7:0] MODE_CSP = 8'h08;
  localparam logic [7:0] MODE_CSV = 8'h09;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DS_NOT_READY      = 3'h0,
    DS_SW_ON_DISABLED = 3'h1,
    DS_READY          = 3'h2,
    DS_SWITCHED_ON    = 3'h3,
    DS_OP_ENABLED     = 3'h4,
    DS_QS_ACTIVE      = 3'h5,
    DS_FAULT_REACT    = 3'h6,
    DS_FAULT          = 3'h7
  } drive_state_type;

  typedef enum logic [1:0] {
    DECEL_NONE    = 2'h0,
    DECEL_PROFILE = 2'h1,
    DECEL_QUICK   = 2'h2,
    DECEL_IMMED   = 2'h3
  } decel_type;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_QS_STOP   = 3'h1,
    ST_QS_HOLD   = 3'h2,
    ST_OFF_STOP  = 3'h3,
    ST_EXT_STOP  = 3'h4,
    ST_HALT_STOP = 3'h5,
    ST_HALT_HOLD = 3'h6,
    ST_DEEXCITED = 3'h7
  } stop_state_type;

endpackage : drive_stop_pkg

// ### action_code_reg.sv
// Purpose: One stop-action option code with value check
// Assumes: Writes are one-cycle strobes
// Notes:   A bit map picks the legal codes
`timescale 1ns/1ps
module action_code_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [7:0]  LEGAL_MAP   = 8'h00
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_wdata,
  output logic             o_legal,
  output logic [15:0]      o_value
);
  import drive_stop_pkg::*;

  // Upper bits must be zero, so negative codes are refused too
  assign o_legal = (i_wdata[15:3] == 13'h0000) && LEGAL_MAP[i_wdata[2:0]];   // RULE_17

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_value <= RESET_VALUE;
    end else if (i_wr && o_legal) begin
      o_value <= i_wdata;   // RULE_17
    end
  end

endmodule : action_code_reg

// ### drive_status_stop.sv
// Purpose: Status word build and stop-action sequencing
// Assumes: State and motion flags come from nearby logic
// Notes:   Accesses answer one cycle after the strobe
`timescale 1ns/1ps
module drive_status_stop (
  input  wire logic                            I_SYS_CLK,
  input  wire logic                            I_RST,
  input  wire logic                            i_OBJ_WR,
  input  wire logic                            i_OBJ_RD,
  input  wire logic [15:0]                     i_OBJ_INDEX,
  input  wire logic [15:0]                     i_OBJ_WDATA,
  input  wire drive_stop_pkg::drive_state_type i_DRIVE_STATE,
  input  wire logic                            i_VOLTAGE_ON,
  input  wire logic                            i_INFO_ACTIVE,
  input  wire logic                            i_INIT_DONE,
  input  wire logic [7:0]                      i_OP_MODE,
  input  wire logic                            i_POS_IN_WINDOW,
  input  wire logic                            i_VEL_REACHED,
  input  wire logic                            i_HOME_DONE,
  input  wire logic                            i_INTERNAL_LIMIT,
  input  wire logic                            i_QUICK_STOP_CMD,
  input  wire logic                            i_SHUTDOWN_CMD,
  input  wire logic                            i_DISABLE_OP_CMD,
  input  wire logic                            i_HALT,
  input  wire logic                            i_EXT_STOP,
  input  wire logic                            i_CONTROLLER_DECEL_STOP_BIT,
  input  wire logic                            i_QS_RELEASE,
  input  wire logic                            i_EXCITE_CMD,
  input  wire logic                            i_MOTOR_STOPPED,
  output logic [15:0]                          o_OBJ_RDATA,
  output logic                                 o_OBJ_ACK,
  output logic                                 o_OBJ_REFUSED,
  output logic [15:0]                          o_STATUS_WORD,
  output drive_stop_pkg::decel_type            o_DECEL_SEL,
  output logic                                 o_CURRENT_OFF,
  output logic                                 o_TO_SW_ON_DISABLED,
  output logic                                 o_HOLD_QS_ACTIVE
);
  import drive_stop_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0]    qs_action;
  logic [15:0]    shut_action;
  logic [15:0]    dis_action;
  logic [15:0]    halt_action;
  logic           qs_legal;
  logic           shut_legal;
  logic           dis_legal;
  logic           halt_legal;
  logic           wr_qs;
  logic           wr_shut;
  logic           wr_dis;
  logic           wr_halt;
  logic [2:0]     qs_latched_reg;
  logic           init_done_reg;
  logic           target_next;
  logic           ext_qs_seen_reg;
  stop_state_type state_reg;
  stop_state_type state_next;
  decel_type      decel_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] state_bits(input drive_state_type st);
    logic [6:0] b;
    b = 7'h00;
    case (st)
      DS_NOT_READY:      b = 7'h00;
      DS_SW_ON_DISABLED: b = 7'h40;
      DS_READY:          b = 7'h21;
      DS_SWITCHED_ON:    b = 7'h23;
      DS_OP_ENABLED:     b = 7'h27;
      DS_QS_ACTIVE:      b = 7'h07;
      DS_FAULT_REACT:    b = 7'h0F;
      DS_FAULT:          b = 7'h08;
      default:           b = 7'h00;
    endcase
    return b;
  endfunction : state_bits

  // Codes 1..3 and 5..7 share a rate in their low two bits
  function automatic decel_type rate_of(input logic [2:0] code);
    decel_type d;
    d = DECEL_NONE;
    case (code[1:0])
      2'h1:    d = DECEL_PROFILE;
      2'h2:    d = DECEL_QUICK;
      2'h3:    d = DECEL_IMMED;
      default: d = DECEL_NONE;
    endcase
    return d;
  endfunction : rate_of

  // ----------------------------------------------------------------
  // Option code storage
  // ----------------------------------------------------------------
  assign wr_qs   = i_OBJ_WR && (i_OBJ_INDEX == IDX_QS_ACTION);
  assign wr_shut = i_OBJ_WR && (i_OBJ_INDEX == IDX_SHUT_ACTION);
  assign wr_dis  = i_OBJ_WR && (i_OBJ_INDEX == IDX_DIS_ACTION);
  assign wr_halt = i_OBJ_WR && (i_OBJ_INDEX == IDX_HALT_ACTION);

  action_code_reg #(
    .RESET_VALUE (RST_QS_ACTION),
    .LEGAL_MAP   (LEGAL_QS)
  ) u_qs_action (   // RULE_06
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_RST),
    .i_wr    (wr_qs),
    .i_wdata (i_OBJ_WDATA),
    .o_legal (qs_legal),
    .o_value (qs_action)
  );

  action_code_reg #(
    .RESET_VALUE (RST_SHUT_ACTION),
    .LEGAL_MAP   (LEGAL_ONOFF)
  ) u_shut_action (   // RULE_12
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_RST),
    .i_wr    (wr_shut),
    .i_wdata (i_OBJ_WDATA),
    .o_legal (shut_legal),
    .o_value (shut_action)
  );

  action_code_reg #(
    .RESET_VALUE (RST_DIS_ACTION),
    .LEGAL_MAP   (LEGAL_ONOFF)
  ) u_dis_action (   // RULE_13
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_RST),
    .i_wr    (wr_dis),
    .i_wdata (i_OBJ_WDATA),
    .o_legal (dis_legal),
    .o_value (dis_action)
  );

  action_code_reg #(
    .RESET_VALUE (RST_HALT_ACTION),
    .LEGAL_MAP   (LEGAL_HALT)
  ) u_halt_action (   // RULE_15
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_RST),
    .i_wr    (wr_halt),
    .i_wdata (i_OBJ_WDATA),
    .o_legal (halt_legal),
    .o_value (halt_action)
  );

  // ----------------------------------------------------------------
  // Object access answer
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      o_OBJ_ACK     <= 1'b0;
      o_OBJ_REFUSED <= 1'b0;
      o_OBJ_RDATA   <= 16'h0000;
    end else begin
      o_OBJ_ACK     <= i_OBJ_WR || i_OBJ_RD;
      o_OBJ_REFUSED <= 1'b0;
      if (i_OBJ_WR) begin
        // Status word is read-only; unknown indices are refused
        o_OBJ_REFUSED <= !((wr_qs && qs_legal) || (wr_shut && shut_legal) ||
                           (wr_dis && dis_legal) || (wr_halt && halt_legal));   // RULE_17
      end else if (i_OBJ_RD) begin
        case (i_OBJ_INDEX)
          IDX_STATUS:      o_OBJ_RDATA <= o_STATUS_WORD;
          IDX_QS_ACTION:   o_OBJ_RDATA <= qs_action;
          IDX_SHUT_ACTION: o_OBJ_RDATA <= shut_action;
          IDX_DIS_ACTION:  o_OBJ_RDATA <= dis_action;
          IDX_HALT_ACTION: o_OBJ_RDATA <= halt_action;
          default: begin
            o_OBJ_RDATA   <= 16'h0000;
            o_OBJ_REFUSED <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  always_comb begin
    case (i_OP_MODE)
      MODE_PP, MODE_CSP: target_next = i_POS_IN_WINDOW;   // RULE_04
      MODE_PV, MODE_CSV: target_next = i_VEL_REACHED;     // RULE_04
      MODE_HM:           target_next = i_HOME_DONE;       // RULE_04
      default:           target_next = 1'b0;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      init_done_reg <= 1'b0;
    end else if (i_INIT_DONE) begin
      init_done_reg <= 1'b1;   // RULE_03
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      o_STATUS_WORD <= 16'h0000;
    end else begin
      o_STATUS_WORD              <= 16'h0000;
      o_STATUS_WORD[6:0]         <= state_bits(i_DRIVE_STATE);   // RULE_01
      o_STATUS_WORD[4]           <= i_VOLTAGE_ON;                // RULE_01
      o_STATUS_WORD[BIT_WARNING] <= i_INFO_ACTIVE;               // RULE_02
      o_STATUS_WORD[BIT_REMOTE]  <= init_done_reg;               // RULE_03
      o_STATUS_WORD[BIT_TARGET]  <= target_next;                 // RULE_04
      o_STATUS_WORD[BIT_ILIMIT]  <= i_INTERNAL_LIMIT;            // RULE_05
    end
  end

  // ----------------------------------------------------------------
  // Stop sequencer
  // ----------------------------------------------------------------
  // Quick stop code is frozen at entry so a mid-stop write waits
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      qs_latched_reg <= RST_QS_ACTION[2:0];
    end else if (state_reg != ST_QS_STOP) begin
      qs_latched_reg <= qs_action[2:0];   // RULE_07
    end
  end

  // Quick stop seen in an external stop runs at standstill
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      ext_qs_seen_reg <= 1'b0;
    end else if (state_reg != ST_EXT_STOP) begin
      ext_qs_seen_reg <= 1'b0;
    end else if (i_QUICK_STOP_CMD) begin
      ext_qs_seen_reg <= 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    decel_next = o_DECEL_SEL;
    case (state_reg)
      ST_IDLE: begin
        decel_next = DECEL_NONE;
        if (i_QUICK_STOP_CMD) begin
          state_next = ST_QS_STOP;
          decel_next = rate_of(qs_action[2:0]);   // RULE_08 RULE_09
        end else if (i_EXT_STOP || i_CONTROLLER_DECEL_STOP_BIT) begin
          state_next = ST_EXT_STOP;
          decel_next = DECEL_PROFILE;
        end else if (i_SHUTDOWN_CMD || i_DISABLE_OP_CMD) begin
          state_next = ST_OFF_STOP;
          decel_next = (i_SHUTDOWN_CMD ? shut_action[0] : dis_action[0]) ?
                       DECEL_PROFILE : DECEL_NONE;   // RULE_14
        end else if (i_HALT) begin
          state_next = ST_HALT_STOP;
          decel_next = rate_of(halt_action[2:0]);   // RULE_16
        end
      end
      ST_OFF_STOP, ST_HALT_STOP: begin
        if (i_QUICK_STOP_CMD) begin
          state_next = ST_QS_STOP;
          decel_next = DECEL_QUICK;   // RULE_10
        end else if (i_MOTOR_STOPPED || decel_next == DECEL_NONE) begin
          state_next = (state_reg == ST_HALT_STOP) ? ST_HALT_HOLD : ST_DEEXCITED;
          decel_next = DECEL_NONE;   // RULE_14 RULE_16
        end
      end
      ST_EXT_STOP: begin
        // Rate kept despite a later quick stop
        if (i_MOTOR_STOPPED) begin   // RULE_11
          state_next = ext_qs_seen_reg ? ST_QS_STOP : ST_IDLE;
          decel_next = DECEL_NONE;
        end
      end
      ST_QS_STOP: begin
        if (i_MOTOR_STOPPED || decel_next == DECEL_NONE) begin
          decel_next = DECEL_NONE;
          state_next = qs_latched_reg[2] ? ST_QS_HOLD : ST_DEEXCITED;   // RULE_08 RULE_09
        end
      end
      ST_QS_HOLD: begin
        if (i_QS_RELEASE) begin
          state_next = ST_IDLE;
        end
      end
      ST_HALT_HOLD: begin
        if (!i_HALT) begin
          state_next = ST_IDLE;
        end
      end
      ST_DEEXCITED: begin
        if (i_EXCITE_CMD) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        decel_next = DECEL_NONE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      state_reg   <= ST_IDLE;
      o_DECEL_SEL <= DECEL_NONE;
    end else begin
      state_reg   <= state_next;
      o_DECEL_SEL <= decel_next;
    end
  end

  // Current is off when de-excited or in a zero-code stop
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      o_CURRENT_OFF <= 1'b0;
    end else begin
      o_CURRENT_OFF <= (state_next == ST_DEEXCITED) ||
                       ((state_next != ST_IDLE) && (state_next != ST_EXT_STOP) &&
                        (state_next != ST_HALT_STOP) && (state_next != ST_HALT_HOLD) &&
                        (decel_next == DECEL_NONE) && (state_next != ST_QS_HOLD));   // RULE_08 RULE_14
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      o_TO_SW_ON_DISABLED <= 1'b0;
      o_HOLD_QS_ACTIVE    <= 1'b0;
    end else begin
      o_TO_SW_ON_DISABLED <= (state_reg == ST_QS_STOP) && (state_next == ST_DEEXCITED);   // RULE_08
      o_HOLD_QS_ACTIVE    <= (state_next == ST_QS_HOLD);   // RULE_09
    end
  end

endmodule : drive_status_stop

// ### drive_status_stop_monitor.sv
// Purpose: Port checks of status and stops
// Assumes: One clock, sync reset
// Notes:   Antecedents avoid racing stops
`timescale 1ns/1ps
module drive_status_stop_monitor (
  input wire logic                      I_SYS_CLK,
  input wire logic                      I_RST,
  input wire logic                      i_OBJ_WR,
  input wire logic [15:0]               i_OBJ_INDEX,
  input wire logic [15:0]               i_OBJ_WDATA,
  input wire logic                      i_INFO_ACTIVE,
  input wire logic                      i_INIT_DONE,
  input wire logic                      i_INTERNAL_LIMIT,
  input wire logic                      i_QUICK_STOP_CMD,
  input wire logic                      i_HALT,
  input wire logic                      i_EXT_STOP,
  input wire logic                      i_CONTROLLER_DECEL_STOP_BIT,
  input wire logic                      i_QS_RELEASE,
  input wire logic                      i_MOTOR_STOPPED,
  input wire logic                      o_OBJ_ACK,
  input wire logic                      o_OBJ_REFUSED,
  input wire logic [15:0]               o_STATUS_WORD,
  input wire drive_stop_pkg::decel_type o_DECEL_SEL,
  input wire logic                      o_CURRENT_OFF,
  input wire logic                      o_TO_SW_ON_DISABLED,
  input wire logic                      o_HOLD_QS_ACTIVE
);
  import drive_stop_pkg::*;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  sequence halt_decel;
    i_HALT && !i_EXT_STOP && !i_CONTROLLER_DECEL_STOP_BIT && !i_MOTOR_STOPPED
      && o_DECEL_SEL == DECEL_PROFILE;
  endsequence
  sequence pulse_then_clear;
    o_CURRENT_OFF ##1 !o_TO_SW_ON_DISABLED;
  endsequence
  a_warn_follows_info: assert property (
    1'b1 |=> o_STATUS_WORD[7] == $past(i_INFO_ACTIVE)) else $error("warning bit stale");
  a_limit_flag_follows: assert property (
    1'b1 |=> o_STATUS_WORD[11] == $past(i_INTERNAL_LIMIT)) else $error("limit bit stale");
  a_remote_set: assert property (
    i_INIT_DONE |-> ##2 o_STATUS_WORD[9]) else $error("remote bit not set");
  a_remote_sticks: assert property (
    o_STATUS_WORD[9] |=> o_STATUS_WORD[9]) else $error("remote bit dropped");
  a_halt_code_refused: assert property (
    i_OBJ_WR && i_OBJ_INDEX == IDX_HALT_ACTION && i_OBJ_WDATA == 16'h0000
      |=> o_OBJ_ACK && o_OBJ_REFUSED) else $error("halt code 0 accepted");
  a_quick_rate_switch: assert property (
    halt_decel ##0 i_QUICK_STOP_CMD |=> o_DECEL_SEL == DECEL_QUICK)
    else $error("rate not switched");
  a_ext_rate_kept: assert property (
    i_EXT_STOP && !i_MOTOR_STOPPED && o_DECEL_SEL == DECEL_PROFILE && i_QUICK_STOP_CMD
      |=> o_DECEL_SEL == DECEL_PROFILE) else $error("ext rate changed");
  a_hold_stays: assert property (
    o_HOLD_QS_ACTIVE && !i_QS_RELEASE |=> o_HOLD_QS_ACTIVE) else $error("hold left early");
  a_swod_pulse: assert property (
    o_TO_SW_ON_DISABLED |-> pulse_then_clear) else $error("bad disable pulse");
endmodule : drive_status_stop_monitor

bind drive_status_stop drive_status_stop_monitor u_mon (.I_SYS_CLK, .I_RST, .i_OBJ_WR,
  .i_OBJ_INDEX, .i_OBJ_WDATA, .i_INFO_ACTIVE, .i_INIT_DONE, .i_INTERNAL_LIMIT,
  .i_QUICK_STOP_CMD, .i_HALT, .i_EXT_STOP, .i_CONTROLLER_DECEL_STOP_BIT, .i_QS_RELEASE,
  .i_MOTOR_STOPPED, .o_OBJ_ACK, .o_OBJ_REFUSED, .o_STATUS_WORD, .o_DECEL_SEL,
  .o_CURRENT_OFF, .o_TO_SW_ON_DISABLED, .o_HOLD_QS_ACTIVE);

// ### fieldbus_master_model.sv
// Purpose: Master making object accesses
// Assumes: One-cycle strobes
// Notes:   Released data shows its inverse
`timescale 1ns/1ps
module fieldbus_master_model (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic        i_refused,
  input  wire logic [15:0] i_rdata,
  output logic             o_wr,
  output logic             o_rd,
  output logic [15:0]      o_index,
  output logic [15:0]      o_wdata
);
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_index = 16'h0000;
    o_wdata = 16'h0000;
  end
  // ----------------------------------------------------------------
  // Object access
  // ----------------------------------------------------------------
  task automatic access(input logic w, input logic [15:0] idx, d,
                        output logic [15:0] rdata, output logic [1:0] ans);
    @(posedge i_clk);
    o_wr    <= w;
    o_rd    <= !w;
    o_index <= idx;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
    o_wdata <= ~d;
    #1;
    rdata = i_rdata;
    ans   = {i_ack, i_refused};
  endtask : access
endmodule : fieldbus_master_model

// ### tb_top.sv
// Purpose: Bench for status and stop options
// Assumes: Model drives the object bus
// Notes:   Scenarios start from reset
`timescale 1ns/1ps
module tb_top;
  import drive_stop_pkg::*;
  localparam int QS = 0, SHUT = 1, DIS = 2, HALT = 3, EXT = 4, CTL = 5, REL = 6, STOP = 8;
  logic            I_SYS_CLK, I_RST, i_OBJ_WR, i_OBJ_RD, o_OBJ_ACK, o_OBJ_REFUSED;
  logic            i_VOLTAGE_ON, i_INFO_ACTIVE, i_INIT_DONE, i_POS_IN_WINDOW, i_VEL_REACHED;
  logic            i_HOME_DONE, i_INTERNAL_LIMIT, o_CURRENT_OFF, o_TO_SW_ON_DISABLED;
  logic            o_HOLD_QS_ACTIVE;
  logic [15:0]     i_OBJ_INDEX, i_OBJ_WDATA, o_OBJ_RDATA, o_STATUS_WORD, rd_v;
  logic [8:0]      cmd;
  logic [7:0]      i_OP_MODE;
  logic [1:0]      ans;
  drive_state_type i_DRIVE_STATE;
  decel_type       o_DECEL_SEL;
  int              errors, checked;
  drive_status_stop dut (.I_SYS_CLK, .I_RST, .i_OBJ_WR, .i_OBJ_RD, .i_OBJ_INDEX, .i_OBJ_WDATA,
    .i_DRIVE_STATE, .i_VOLTAGE_ON, .i_INFO_ACTIVE, .i_INIT_DONE, .i_OP_MODE, .i_POS_IN_WINDOW,
    .i_VEL_REACHED, .i_HOME_DONE, .i_INTERNAL_LIMIT, .i_QUICK_STOP_CMD(cmd[0]),
    .i_SHUTDOWN_CMD(cmd[1]), .i_DISABLE_OP_CMD(cmd[2]), .i_HALT(cmd[3]), .i_EXT_STOP(cmd[4]),
    .i_CONTROLLER_DECEL_STOP_BIT(cmd[5]), .i_QS_RELEASE(cmd[6]), .i_EXCITE_CMD(cmd[7]),
    .i_MOTOR_STOPPED(cmd[8]), .o_OBJ_RDATA, .o_OBJ_ACK, .o_OBJ_REFUSED, .o_STATUS_WORD,
    .o_DECEL_SEL, .o_CURRENT_OFF, .o_TO_SW_ON_DISABLED, .o_HOLD_QS_ACTIVE);
  fieldbus_master_model master (.i_clk(I_SYS_CLK), .i_ack(o_OBJ_ACK), .i_refused(o_OBJ_REFUSED),
    .i_rdata(o_OBJ_RDATA), .o_wr(i_OBJ_WR), .o_rd(i_OBJ_RD), .o_index(i_OBJ_INDEX),
    .o_wdata(i_OBJ_WDATA));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic acc(input logic w, input logic [15:0] i, d, input logic [1:0] ea);
    master.access(w, i, d, rd_v, ans);
    check(16'(ans), 16'(ea));
  endtask : acc
  task automatic pulse(input int b);
    @(posedge I_SYS_CLK);
    cmd[b] <= 1'b1;
    @(posedge I_SYS_CLK);
    cmd[b] <= 1'b0;
    #1;
  endtask : pulse
  task automatic level(input int b, input logic v);
    @(posedge I_SYS_CLK);
    cmd[b] <= v;
    @(posedge I_SYS_CLK);
    #1;
  endtask : level
  task automatic do_reset;
    @(posedge I_SYS_CLK);
    I_RST <= 1'b1;
    cmd   <= 9'h000;
    repeat (10) @(posedge I_SYS_CLK);
    I_RST <= 1'b0;
  endtask : do_reset
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] idx [4] = '{IDX_QS_ACTION, IDX_SHUT_ACTION, IDX_DIS_ACTION, IDX_HALT_ACTION};
    logic [15:0] rv [4] = '{16'h0002, 16'h0001, 16'h0001, 16'h0001};
    logic [7:0]  lm [4] = '{8'hEF, 8'h03, 8'h03, 8'h0E};
    logic [15:0] cur;
    logic        ok;
    do_reset();
    for (int r = 0; r < 4; r++) begin
      acc(1'b0, idx[r], 16'h0000, 2'b10);
      check(rd_v, rv[r]);
      cur = rv[r];
      for (int v = 0; v < 9; v++) begin
        ok = (v < 8) && lm[r][v];
        acc(1'b1, idx[r], 16'(v), {1'b1, !ok});
        if (ok)
          cur = 16'(v);
        acc(1'b0, idx[r], 16'h0000, 2'b10);
        check(rd_v, cur);
      end
    end
    acc(1'b1, IDX_STATUS, 16'h0000, 2'b11);
  endtask : t_regs
  task automatic t_status;
    logic [6:0]  pat [8] = '{7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07, 7'h0F, 7'h08};
    do_reset();
    for (int s = 0; s < 8; s++) begin
      @(posedge I_SYS_CLK);
      i_DRIVE_STATE <= drive_state_type'(s);
      i_VOLTAGE_ON  <= s[0];
      @(posedge I_SYS_CLK);
      #1;
      check(o_STATUS_WORD, {9'h000, pat[s][6:5], s[0], pat[s][3:0]});
    end
    @(posedge I_SYS_CLK);
    i_INFO_ACTIVE    <= 1'b1;
    i_INTERNAL_LIMIT <= 1'b1;
    i_INIT_DONE      <= 1'b1;
    i_POS_IN_WINDOW  <= 1'b1;
    @(posedge I_SYS_CLK);
    i_INIT_DONE <= 1'b0;
    @(posedge I_SYS_CLK);
    #1;
    check(o_STATUS_WORD, 16'h0E98);
    @(posedge I_SYS_CLK);
    i_INFO_ACTIVE    <= 1'b0;
    i_INTERNAL_LIMIT <= 1'b0;
    i_OP_MODE        <= MODE_PV;
    @(posedge I_SYS_CLK);
    #1;
    check(o_STATUS_WORD, 16'h0218);
    acc(1'b0, IDX_STATUS, 16'h0000, 2'b10);
    check(rd_v, 16'h0218);
  endtask : t_status
  task automatic t_qs;
    int c [7] = '{0, 1, 2, 3, 5, 6, 7};
    for (int k = 0; k < 7; k++) begin
      do_reset();
      acc(1'b1, IDX_QS_ACTION, 16'(c[k]), 2'b10);
      pulse(QS);
      check(16'({o_DECEL_SEL, o_CURRENT_OFF}), 16'({c[k][1:0], c[k] == 0}));
      level(STOP, 1'b1);
      check(16'({o_HOLD_QS_ACTIVE, o_CURRENT_OFF, o_TO_SW_ON_DISABLED}),
            c[k] > 4 ? 16'h0004 : (c[k] > 0 ? 16'h0003 : 16'h0002));
    end
    do_reset();
    acc(1'b1, IDX_QS_ACTION, 16'h0006, 2'b10);
    pulse(QS);
    acc(1'b1, IDX_QS_ACTION, 16'h0001, 2'b10);
    level(STOP, 1'b1);
    check(16'({o_HOLD_QS_ACTIVE, o_TO_SW_ON_DISABLED}), 16'h0002);
    pulse(REL);
    level(STOP, 1'b0);
    pulse(QS);
    check(16'(o_DECEL_SEL), 16'h0001);
  endtask : t_qs
  task automatic t_stops;
    for (int c = 1; c < 4; c++) begin
      do_reset();
      acc(1'b1, IDX_HALT_ACTION, 16'(c), 2'b10);
      level(HALT, 1'b1);
      check(16'(o_DECEL_SEL), 16'(c));
      if (c == 1) begin
        pulse(QS);
        check(16'(o_DECEL_SEL), 16'h0002);
      end else begin
        level(STOP, 1'b1);
        check(16'({o_DECEL_SEL, o_CURRENT_OFF, o_HOLD_QS_ACTIVE}), 16'h0000);
      end
    end
    for (int b = EXT; b <= CTL; b++) begin
      do_reset();
      level(b, 1'b1);
      pulse(QS);
      check(16'(o_DECEL_SEL), 16'h0001);
    end
    for (int k = 0; k < 4; k++) begin
      do_reset();
      acc(1'b1, k[1] ? IDX_DIS_ACTION : IDX_SHUT_ACTION, 16'(k[0]), 2'b10);
      pulse(k[1] ? DIS : SHUT);
      check(16'({o_DECEL_SEL, o_CURRENT_OFF}), k[0] ? 16'h0002 : 16'h0001);
      level(STOP, 1'b1);
      check(16'(o_CURRENT_OFF), 16'h0001);
    end
  endtask : t_stops
  // ----------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    I_SYS_CLK = 1'b0;
    forever #5 I_SYS_CLK = ~I_SYS_CLK;
  end
  initial begin
    {i_VOLTAGE_ON, i_INFO_ACTIVE, i_INIT_DONE, i_VEL_REACHED, i_HOME_DONE} = 5'h00;
    {i_POS_IN_WINDOW, i_INTERNAL_LIMIT} = 2'h0;
    I_RST         = 1'b1;
    cmd           = 9'h000;
    i_OP_MODE     = MODE_PP;
    i_DRIVE_STATE = DS_OP_ENABLED;
    errors        = 0;
    checked       = 0;
    t_regs();
    t_status();
    t_qs();
    t_stops();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge I_SYS_CLK);
    errors++;
    stop_test();
  end
endmodule : tb_top
